// ==== hdl/ogs_top.sv ====
// Output gain and offset stage with AXI4-Lite register slave
`timescale 1ns/1ps
// Contract
// - Gains reset to zero, outputs zero
// - Gain bits 14:0 magnitude, 0x2000 unity
// - Gain bit 15 sign, negative inverts
// - Port A gain applies to port A
// - Port B gain applies to port B
// - Offset aligned to upper 16 sample bits
// - One channel uses channel-0 I/Q offsets
// - Two channel adds channel-1 offsets on B
// - Real modes use I offsets per channel
// - Offsets reset to zero
// - Correction always in datapath
module ogs_top
	import ogs_pkg::*;
(
	input wire logic I_CLK,
	input wire logic I_ARST_N,
	input wire logic [31:0] I_AWADDR,
	input wire logic I_AWVALID,
	output logic O_AWREADY,
	input wire logic [31:0] I_WDATA,
	input wire logic [3:0] I_WSTRB,
	input wire logic I_WVALID,
	output logic O_WREADY,
	output logic [1:0] O_BRESP,
	output logic O_BVALID,
	input wire logic I_BREADY,
	input wire logic [31:0] I_ARADDR,
	input wire logic I_ARVALID,
	output logic O_ARREADY,
	output logic [31:0] O_RDATA,
	output logic [1:0] O_RRESP,
	output logic O_RVALID,
	input wire logic I_RREADY,
	input wire logic I_VALID,
	input wire ogs_iq_s I_PORT_A,
	input wire ogs_iq_s I_PORT_B,
	output logic O_VALID,
	output ogs_iq_s O_PORT_A,
	output ogs_iq_s O_PORT_B
);
	logic [15:0] gain_a_q, gain_b_q;
	logic [15:0] ofs_i0_q, ofs_q0_q, ofs_i1_q, ofs_q1_q;
	logic [1:0] mode_q;
	logic aw_got_q, w_got_q;
	logic [31:0] awaddr_q, wdata_q;
	logic [3:0] wstrb_q;
	// Write side keeps address and data apart so either may come first
	// Mode register is a local addition; the stage has no other control

	// Index from byte address; unaligned or high addresses miss
	// Bit 8 flags a miss so it can never alias a mapped index
	function automatic logic [8:0] idx_of(input logic [31:0] a);
		if (a[1:0] != 2'b00 || a[31:10] != 22'h00_0000) begin
			idx_of = 9'h1FF;
		end else begin
			idx_of = {1'b0, a[9:2]};
		end
	endfunction : idx_of

	// Mapped window runs from gain A up to the mode register
	function automatic logic hit(input logic [8:0] ix);
		hit = (ix[8] == 1'b0) && (ix[7:0] >= OGS_IDX_GAIN_A) && (ix[7:0] <= OGS_IDX_MODE);
	endfunction : hit

	// Byte lanes 0 and 1 only; upper lanes are not stored
	function automatic logic [15:0] merge(input logic [15:0] old, input logic [31:0] d,
		input logic [3:0] s);
		merge = {s[1] ? d[15:8] : old[15:8], s[0] ? d[7:0] : old[7:0]};
	endfunction : merge

	// Sign-magnitude gain times sample, then offset, then clip
	function automatic logic [OGS_SMP_W-1:0] correct(input logic [OGS_SMP_W-1:0] x,
		input logic [15:0] g, input logic [15:0] o);
		logic signed [34:0] prod;
		logic signed [34:0] sum;
		prod = 35'sd0;
		sum = 35'sd0;
		prod = $signed({{17{x[OGS_SMP_W-1]}}, x}) * $signed({20'h0_0000, g[14:0]});
		// Truncation happens before the sign is applied
		prod = prod >>> OGS_GAIN_FRAC;
		if (g[OGS_GAIN_SIGN_BIT]) begin
			prod = -prod;
		end
		sum = prod + $signed({{17{o[15]}}, o, 2'b00});
		// Clip instead of wrapping: a wrapped peak would flip its sign
		if (sum > 35'sd131071) begin
			correct = 18'h1_FFFF;
		end else if (sum < -35'sd131072) begin
			correct = 18'h2_0000;
		end else begin
			correct = sum[OGS_SMP_W-1:0];
		end
	endfunction : correct

	// Write address and data taken in either order, one write in flight
	// Both flags clear on the edge that launches the response
	always_ff @(posedge I_CLK or negedge I_ARST_N) begin
		if (!I_ARST_N) begin
			aw_got_q <= 1'b0;
			w_got_q <= 1'b0;
			awaddr_q <= 32'h0000_0000;
			wdata_q <= 32'h0000_0000;
			wstrb_q <= 4'h0;
		end else begin
			if (I_AWVALID && O_AWREADY) begin
				aw_got_q <= 1'b1;
				awaddr_q <= I_AWADDR;
			end
			if (I_WVALID && O_WREADY) begin
				w_got_q <= 1'b1;
				wdata_q <= I_WDATA;
				wstrb_q <= I_WSTRB;
			end
			if (aw_got_q && w_got_q) begin
				aw_got_q <= 1'b0;
				w_got_q <= 1'b0;
			end
		end
	end

	// Ready held low once an item is taken, until the response goes out
	// Readies look one cycle ahead so an item is never taken twice
	always_ff @(posedge I_CLK or negedge I_ARST_N) begin
		if (!I_ARST_N) begin
			O_AWREADY <= 1'b0;
			O_WREADY <= 1'b0;
		end else begin
			O_AWREADY <= !aw_got_q && !(I_AWVALID && O_AWREADY) && !O_BVALID;
			O_WREADY <= !w_got_q && !(I_WVALID && O_WREADY) && !O_BVALID;
		end
	end

	// Write response
	// Unmapped writes still answer, with SLVERR, so the master never hangs
	always_ff @(posedge I_CLK or negedge I_ARST_N) begin
		if (!I_ARST_N) begin
			O_BVALID <= 1'b0;
			O_BRESP <= OGS_RESP_OKAY;
		end else if (aw_got_q && w_got_q) begin
			O_BVALID <= 1'b1;
			O_BRESP <= hit(idx_of(awaddr_q)) ? OGS_RESP_OKAY : OGS_RESP_SLVERR;
		end else if (O_BVALID && I_BREADY) begin
			O_BVALID <= 1'b0;
		end
	end

	// Register file; reset leaves gains and offsets at zero
	// Partial strobes merge byte by byte into the old value
	always_ff @(posedge I_CLK or negedge I_ARST_N) begin
		if (!I_ARST_N) begin
			gain_a_q <= OGS_GAIN_RST;
			gain_b_q <= OGS_GAIN_RST;
			ofs_i0_q <= OGS_OFS_RST;
			ofs_q0_q <= OGS_OFS_RST;
			ofs_i1_q <= OGS_OFS_RST;
			ofs_q1_q <= OGS_OFS_RST;
			mode_q <= OGS_MODE_RST;
		end else if (aw_got_q && w_got_q) begin
			case (idx_of(awaddr_q))
				{1'b0, OGS_IDX_GAIN_A}: gain_a_q <= merge(gain_a_q, wdata_q, wstrb_q);
				{1'b0, OGS_IDX_GAIN_B}: gain_b_q <= merge(gain_b_q, wdata_q, wstrb_q);
				{1'b0, OGS_IDX_OFS_I0}: ofs_i0_q <= merge(ofs_i0_q, wdata_q, wstrb_q);
				{1'b0, OGS_IDX_OFS_Q0}: ofs_q0_q <= merge(ofs_q0_q, wdata_q, wstrb_q);
				{1'b0, OGS_IDX_OFS_I1}: ofs_i1_q <= merge(ofs_i1_q, wdata_q, wstrb_q);
				{1'b0, OGS_IDX_OFS_Q1}: ofs_q1_q <= merge(ofs_q1_q, wdata_q, wstrb_q);
				{1'b0, OGS_IDX_MODE}: begin
					if (wstrb_q[0]) begin
						mode_q <= wdata_q[1:0];
					end
				end
				default: begin
				end
			endcase
		end
	end

	// Read channel; answer one cycle after the address is taken
	// Register values are sampled on the address edge, not later
	always_ff @(posedge I_CLK or negedge I_ARST_N) begin
		if (!I_ARST_N) begin
			O_ARREADY <= 1'b0;
			O_RVALID <= 1'b0;
			O_RDATA <= 32'h0000_0000;
			O_RRESP <= OGS_RESP_OKAY;
		end else begin
			O_ARREADY <= !O_RVALID && !(I_ARVALID && O_ARREADY);
			if (I_ARVALID && O_ARREADY) begin
				O_RVALID <= 1'b1;
				O_RRESP <= hit(idx_of(I_ARADDR)) ? OGS_RESP_OKAY : OGS_RESP_SLVERR;
				case (idx_of(I_ARADDR))
					{1'b0, OGS_IDX_GAIN_A}: O_RDATA <= {16'h0000, gain_a_q};
					{1'b0, OGS_IDX_GAIN_B}: O_RDATA <= {16'h0000, gain_b_q};
					{1'b0, OGS_IDX_OFS_I0}: O_RDATA <= {16'h0000, ofs_i0_q};
					{1'b0, OGS_IDX_OFS_Q0}: O_RDATA <= {16'h0000, ofs_q0_q};
					{1'b0, OGS_IDX_OFS_I1}: O_RDATA <= {16'h0000, ofs_i1_q};
					{1'b0, OGS_IDX_OFS_Q1}: O_RDATA <= {16'h0000, ofs_q1_q};
					{1'b0, OGS_IDX_MODE}: O_RDATA <= {30'h0000_0000, mode_q};
					default: O_RDATA <= 32'h0000_0000;
				endcase
			end else if (O_RVALID && I_RREADY) begin
				O_RVALID <= 1'b0;
			end
		end
	end

	// Offset routing per mode: bit0 two-channel, bit1 real output
	// Real output has no Q leg, so both legs of a port take the I offset
	logic [15:0] oa_i, oa_q, ob_i, ob_q;
	always_comb begin
		oa_i = ofs_i0_q;
		oa_q = ofs_q0_q;
		ob_i = ofs_i0_q;
		ob_q = ofs_q0_q;
		if (mode_q[1]) begin
			// Real samples: both legs carry real data of their channel
			oa_q = ofs_i0_q;
			ob_i = mode_q[0] ? ofs_i1_q : ofs_i0_q;
			ob_q = ob_i;
		end else if (mode_q[0]) begin
			ob_i = ofs_i1_q;
			ob_q = ofs_q1_q;
		end
	end

	// Single-stage pipe; never bypassed so zero gain leaves only the aligned offset at the output
	// Outputs hold between samples; the converter looks only when valid
	always_ff @(posedge I_CLK or negedge I_ARST_N) begin
		if (!I_ARST_N) begin
			O_VALID <= 1'b0;
			O_PORT_A <= '0;
			O_PORT_B <= '0;
		end else begin
			O_VALID <= I_VALID;
			if (I_VALID) begin
				O_PORT_A.i <= correct(I_PORT_A.i, gain_a_q, oa_i);
				O_PORT_A.q <= correct(I_PORT_A.q, gain_a_q, oa_q);
				O_PORT_B.i <= correct(I_PORT_B.i, gain_b_q, ob_i);
				O_PORT_B.q <= correct(I_PORT_B.q, gain_b_q, ob_q);
			end
		end
	end

	// Checks
	// Arithmetic checks with fixed operands
	a_zero_gain_out: assert property (@(posedge I_CLK) disable iff (!I_ARST_N)
		(I_VALID && gain_a_q == 16'h0000 && oa_i == 16'h0000) |=> O_PORT_A.i == 18'h0_0000)
		else $error("zero gain A did not give zero");
	a_unity_pass: assert property (@(posedge I_CLK) disable iff (!I_ARST_N)
		(I_VALID && gain_b_q == 16'h2000 && ob_i == 16'h0000) |=> O_PORT_B.i == $past(I_PORT_B.i))
		else $error("unity gain B altered sample");
	a_neg_inverts: assert property (@(posedge I_CLK) disable iff (!I_ARST_N)
		(I_VALID && gain_a_q == 16'hA000 && oa_q == 16'h0000 && I_PORT_A.q == 18'h0_0100)
		|=> O_PORT_A.q == 18'h3_FF00)
		else $error("negative gain did not invert");
	a_offset_align: assert property (@(posedge I_CLK) disable iff (!I_ARST_N)
		(I_VALID && gain_a_q == 16'h0000 && oa_i == 16'h0001) |=> O_PORT_A.i == 18'h0_0004)
		else $error("offset not aligned to upper bits");
	a_sat_high: assert property (@(posedge I_CLK) disable iff (!I_ARST_N)
		(I_VALID && gain_b_q == 16'h7FFF && ob_q == 16'h0000 && I_PORT_B.q == 18'h1_FFFF)
		|=> O_PORT_B.q == 18'h1_FFFF)
		else $error("no saturation on overflow");
	// Routing checks, then valid follow, port B own gain and read answer
	a_two_chan_ofs: assert property (@(posedge I_CLK) disable iff (!I_ARST_N)
		mode_q == 2'b01 |-> (ob_i == ofs_i1_q && ob_q == ofs_q1_q && oa_q == ofs_q0_q))
		else $error("two-channel offset routing wrong");
	a_one_chan_ofs: assert property (@(posedge I_CLK) disable iff (!I_ARST_N)
		mode_q == 2'b00 |-> (oa_i == ofs_i0_q && oa_q == ofs_q0_q))
		else $error("one-channel offset routing wrong");
	a_real_ofs: assert property (@(posedge I_CLK) disable iff (!I_ARST_N)
		mode_q == 2'b11 |-> (oa_q == ofs_i0_q && ob_q == ofs_i1_q))
		else $error("real-mode offset routing wrong");
	a_valid_follow: assert property (@(posedge I_CLK) disable iff (!I_ARST_N)
		I_VALID |=> O_VALID)
		else $error("sample dropped from datapath");
	a_port_indep: assert property (@(posedge I_CLK) disable iff (!I_ARST_N)
		(I_VALID && gain_b_q == 16'h0000 && ob_q == 16'h0000) |=> O_PORT_B.q == 18'h0_0000)
		else $error("port B not using own gain");
	a_rd_answer: assert property (@(posedge I_CLK) disable iff (!I_ARST_N)
		(I_ARVALID && O_ARREADY) |=> O_RVALID)
		else $error("read answer late");
	// Address channel closes for the cycle after it takes an item
	a_aw_taken: assert property (@(posedge I_CLK) disable iff (!I_ARST_N)
		(I_AWVALID && O_AWREADY) |=> !O_AWREADY)
		else $error("write address taken twice");
	// Data channel closes for the cycle after it takes an item
	a_w_taken: assert property (@(posedge I_CLK) disable iff (!I_ARST_N)
		(I_WVALID && O_WREADY) |=> !O_WREADY)
		else $error("write data taken twice");
	// No new write while a response is pending
	a_wr_busy: assert property (@(posedge I_CLK) disable iff (!I_ARST_N)
		O_BVALID |-> (!O_AWREADY && !O_WREADY))
		else $error("write taken during response");
	// Response follows once both halves are in
	a_wr_answer: assert property (@(posedge I_CLK) disable iff (!I_ARST_N)
		(aw_got_q && w_got_q) |=> O_BVALID)
		else $error("write answer late");
	// Response stands until the master takes it
	a_b_stands: assert property (@(posedge I_CLK) disable iff (!I_ARST_N)
		(O_BVALID && !I_BREADY) |=> O_BVALID)
		else $error("write response dropped");
	// Response code stands with it
	a_bresp_stands: assert property (@(posedge I_CLK) disable iff (!I_ARST_N)
		(O_BVALID && !I_BREADY) |=> $stable(O_BRESP))
		else $error("write response code changed");
	// No new read while read data is pending
	a_rd_busy: assert property (@(posedge I_CLK) disable iff (!I_ARST_N)
		O_RVALID |-> !O_ARREADY)
		else $error("read taken during answer");
	// Read data valid stands until taken
	a_r_stands: assert property (@(posedge I_CLK) disable iff (!I_ARST_N)
		(O_RVALID && !I_RREADY) |=> O_RVALID)
		else $error("read answer dropped");
	// Read data word stands with it
	a_rdata_stands: assert property (@(posedge I_CLK) disable iff (!I_ARST_N)
		(O_RVALID && !I_RREADY) |=> $stable(O_RDATA))
		else $error("read data changed");
	// Datapath timing checks, then the low saturation check
	// No sample in, no sample out
	a_valid_drop: assert property (@(posedge I_CLK) disable iff (!I_ARST_N)
		!I_VALID |=> !O_VALID)
		else $error("spurious output sample");
	// Port A holds its last result between samples
	a_hold_a: assert property (@(posedge I_CLK) disable iff (!I_ARST_N)
		!I_VALID |=> $stable(O_PORT_A))
		else $error("port A changed without sample");
	// Port B holds its last result between samples
	a_hold_b: assert property (@(posedge I_CLK) disable iff (!I_ARST_N)
		!I_VALID |=> $stable(O_PORT_B))
		else $error("port B changed without sample");
	// Most negative sample with full boost clips low
	a_sat_low: assert property (@(posedge I_CLK) disable iff (!I_ARST_N)
		(I_VALID && gain_b_q == 16'h7FFF && ob_i == 16'h0000 && I_PORT_B.i == 18'h2_0000)
		|=> O_PORT_B.i == 18'h2_0000)
		else $error("no saturation on underflow");
	// Cover points for the main scenarios
	c_write: cover property (@(posedge I_CLK) disable iff (!I_ARST_N) O_BVALID && I_BREADY);
	c_real_mode: cover property (@(posedge I_CLK) disable iff (!I_ARST_N)
		I_VALID && mode_q == 2'b11);
	c_read: cover property (@(posedge I_CLK) disable iff (!I_ARST_N) O_RVALID && I_RREADY);
	c_two_chan: cover property (@(posedge I_CLK) disable iff (!I_ARST_N) I_VALID && mode_q == 2'b01);
	c_neg_gain: cover property (@(posedge I_CLK) disable iff (!I_ARST_N) I_VALID && gain_a_q[15]);
endmodule : ogs_top

// ==== shared/ogs_pkg.sv ====
// Package for the output gain and offset stage: map, reset values, carriers
package ogs_pkg;
	// Printed offsets are not multiples of four, so they are indices
	localparam logic [7:0] OGS_IDX_GAIN_A = 8'hF3;
	localparam logic [7:0] OGS_IDX_GAIN_B = 8'hF4;
	localparam logic [7:0] OGS_IDX_OFS_I0 = 8'hF5;
	localparam logic [7:0] OGS_IDX_OFS_Q0 = 8'hF6;
	localparam logic [7:0] OGS_IDX_OFS_I1 = 8'hF7;
	localparam logic [7:0] OGS_IDX_OFS_Q1 = 8'hF8;
	localparam logic [7:0] OGS_IDX_MODE = 8'hF9;
	localparam logic [15:0] OGS_GAIN_RST = 16'h0000;
	localparam logic [15:0] OGS_OFS_RST = 16'h0000;
	localparam logic [1:0] OGS_MODE_RST = 2'b00;
	localparam int OGS_GAIN_SIGN_BIT = 15;
	localparam int OGS_GAIN_FRAC = 13;
	localparam logic [1:0] OGS_RESP_OKAY = 2'b00;
	localparam logic [1:0] OGS_RESP_SLVERR = 2'b10;
	localparam int OGS_SMP_W = 18;

	// One I/Q sample pair on a port
	typedef struct packed {
		logic [OGS_SMP_W-1:0] i;
		logic [OGS_SMP_W-1:0] q;
	} ogs_iq_s;
endpackage : ogs_pkg

// ==== dv/ogs_dac_model.sv ====
// Downstream converter model: latches each corrected sample pair
`timescale 1ns/1ps
module ogs_dac_model
	import ogs_pkg::*;
(
	input wire logic i_clk,
	input wire logic i_valid,
	input wire ogs_iq_s i_a,
	input wire ogs_iq_s i_b,
	output logic o_got,
	output ogs_iq_s o_a,
	output ogs_iq_s o_b
);
	// Converter takes every valid word, it cannot push back
	always_ff @(posedge i_clk) begin
		o_got <= i_valid;
		if (i_valid) begin
			o_a <= i_a;
			o_b <= i_b;
		end
	end
endmodule : ogs_dac_model

// ==== dv/tb_ogs_top.sv ====
// Self-checking bench for the output gain and offset stage
`timescale 1ns/1ps
module tb_ogs_top;
	import ogs_pkg::*;
	typedef struct packed {ogs_iq_s a; ogs_iq_s b;} ogs_pair_s;
	logic clk = 0;
	logic arst_n = 0;
	logic [31:0] aw_a = '0, w_d = '0, ar_a = '0, r_d;
	logic aw_v = 0, w_v = 0, b_r = 0, ar_v = 0, r_r = 0, v = 0;
	logic [3:0] w_s = 4'hF;
	logic aw_rdy, w_rdy, b_v, ar_rdy, r_v, o_v, got;
	logic [1:0] b_resp, r_resp;
	ogs_iq_s ia = '0, ib = '0, oa, ob, ca, cb;
	logic [15:0] sh [7];
	logic [31:0] gt [4] = '{32'h2000_4000, 32'hA000_7FFF, 32'hFFFF_1FFF, 32'h0001_8000};
	ogs_pair_s exq [$];
	ogs_pair_s ex;
	int n_errors = 0, checks = 0, cyc = 0;

	ogs_top uut (.I_CLK(clk), .I_ARST_N(arst_n), .I_AWADDR(aw_a), .I_AWVALID(aw_v),
		.O_AWREADY(aw_rdy), .I_WDATA(w_d), .I_WSTRB(w_s), .I_WVALID(w_v), .O_WREADY(w_rdy),
		.O_BRESP(b_resp), .O_BVALID(b_v), .I_BREADY(b_r), .I_ARADDR(ar_a), .I_ARVALID(ar_v),
		.O_ARREADY(ar_rdy), .O_RDATA(r_d), .O_RRESP(r_resp), .O_RVALID(r_v), .I_RREADY(r_r),
		.I_VALID(v), .I_PORT_A(ia), .I_PORT_B(ib), .O_VALID(o_v), .O_PORT_A(oa), .O_PORT_B(ob));
	ogs_dac_model dac (.i_clk(clk), .i_valid(o_v), .i_a(oa), .i_b(ob), .o_got(got),
		.o_a(ca), .o_b(cb));

	always #5 clk = ~clk;

	task automatic conclude();
		$display("counts: %0d checks, %0d mismatches", checks, n_errors);
		if (n_errors == 0 && checks > 0) $display("Simulation passed");
		else $display("Simulation failed");
		$finish;
	endtask : conclude

	task automatic chk(input logic [35:0] g, input logic [35:0] e, input string m);
		checks++;
		if (g !== e) begin
			n_errors++;
			$display("unexpected at %0t: %s got %h exp %h", $time, m, g, e);
		end
	endtask : chk

	// Hang guard, far above the expected run of about six hundred cycles
	always @(posedge clk) begin
		cyc++;
		if (cyc == 5000) begin
			chk(0, 1, "timeout");
			conclude();
		end
	end

	// Byte address is four times the index; bready held until the answer
	task automatic wr(input logic [7:0] idx, input logic [15:0] d, input logic [1:0] er);
		@(posedge clk);
		aw_a <= 32'(idx) << 2;
		w_d <= {16'h0000, d};
		aw_v <= 1;
		w_v <= 1;
		b_r <= 1;
		do begin
			@(posedge clk);
			if (aw_v && aw_rdy) aw_v <= 0;
			if (w_v && w_rdy) w_v <= 0;
		end while (!(b_v && b_r));
		b_r <= 0;
		chk(b_resp, er, "write resp");
	endtask : wr

	task automatic rd(input logic [7:0] idx, input logic [15:0] e, input logic [1:0] er);
		@(posedge clk);
		ar_a <= 32'(idx) << 2;
		ar_v <= 1;
		r_r <= 1;
		do begin
			@(posedge clk);
			if (ar_v && ar_rdy) ar_v <= 0;
		end while (!(r_v && r_r));
		r_r <= 0;
		chk({r_resp, r_d}, {er, 16'h0000, e}, "read");
	endtask : rd

	// Write a setting, keep the shadow copy, read it back
	task automatic set(input int k, input logic [15:0] d);
		wr(OGS_IDX_GAIN_A + 8'(k), d, OGS_RESP_OKAY);
		sh[k] = d;
		rd(OGS_IDX_GAIN_A + 8'(k), d, OGS_RESP_OKAY);
	endtask : set

	task automatic rst();
		arst_n <= 0;
		repeat (3) @(posedge clk);
		arst_n <= 1;
		sh = '{default: 16'h0000};
		@(posedge clk);
		for (int k = 0; k < 7; k++) rd(OGS_IDX_GAIN_A + 8'(k), 16'h0000, OGS_RESP_OKAY);
	endtask : rst

	// Gain first, then offset in the upper 16 bits, one saturation
	function automatic logic [17:0] cor(input logic [17:0] x, input logic [15:0] g,
		input logic [15:0] o);
		longint p;
		p = (longint'($signed(x)) * longint'(g[14:0])) >>> 13;
		if (g[15]) p = -p;
		p = p + 4 * longint'($signed(o));
		if (p > 131071) p = 131071;
		if (p < -131072) p = -131072;
		return p[17:0];
	endfunction : cor

	// Offset routing by mode: bit0 two channels, bit1 real output
	function automatic logic [15:0] ofs(input bit b, input bit q);
		if (b && sh[6][0]) return (q && !sh[6][1]) ? sh[5] : sh[4];
		return (q && !sh[6][1]) ? sh[3] : sh[2];
	endfunction : ofs

	// One sample pair in, its expected result noted
	task automatic drive(input ogs_iq_s xa, input ogs_iq_s xb);
		ogs_pair_s e;
		@(posedge clk);
		v <= 1;
		ia <= xa;
		ib <= xb;
		e.a = {cor(xa.i, sh[0], ofs(0, 0)), cor(xa.q, sh[0], ofs(0, 1))};
		e.b = {cor(xb.i, sh[1], ofs(1, 0)), cor(xb.q, sh[1], ofs(1, 1))};
		exq.push_back(e);
	endtask : drive

	task automatic idle();
		@(posedge clk);
		v <= 0;
		repeat (4) @(posedge clk);
	endtask : idle

	task automatic burst(input int n);
		repeat (n) drive({18'($urandom), 18'($urandom)}, {18'($urandom), 18'($urandom)});
		idle();
	endtask : burst

	// Takes the oldest note whenever the converter latched a word
	always @(posedge clk) begin
		if (got === 1'b1) begin
			if (exq.size() == 0) chk(0, 1, "extra sample");
			else begin
				ex = exq.pop_front();
				chk(ca, ex.a, "port a");
				chk(cb, ex.b, "port b");
			end
		end
	end

	initial begin
		int s;
		s = $urandom(32'h0000_EC39);
		rst();
		burst(4);
		$display("test reset done");
		wr(8'hFA, 16'h1234, OGS_RESP_SLVERR);
		rd(8'hFA, 16'h0000, OGS_RESP_SLVERR);
		$display("test unmapped done");
		// Fixed operands, offsets zero until I0 is set for the last sample, so the datapath checks fire
		set(0, 16'hA000);
		set(1, 16'h2000);
		drive({18'($urandom), 18'h0_0100}, {18'($urandom), 18'($urandom)});
		idle();
		set(1, 16'h7FFF);
		drive({18'($urandom), 18'($urandom)}, {18'h2_0000, 18'h1_FFFF});
		idle();
		set(0, 16'h0000);
		set(2, 16'h0001);
		drive({18'($urandom), 18'($urandom)}, {18'($urandom), 18'($urandom)});
		idle();
		$display("test directed done");
		for (int k = 0; k < 4; k++) begin
			set(0, gt[k][31:16]);
			set(1, gt[k][15:0]);
			for (int j = 2; j < 6; j++) set(j, 16'($urandom));
			for (int m = 0; m < 4; m++) begin
				set(6, 16'(m));
				burst(6);
			end
			$display("test gains %0d done", k);
		end
		rst();
		burst(3);
		$display("test second reset done");
		conclude();
	end
endmodule : tb_ogs_top
